// ===== common/dnm_consts.vh
// constants for the fieldbus slave i/o mapper
`ifndef DNM_CONSTS_VH
`define DNM_CONSTS_VH
// register byte offsets
`define DNM_OFF_CTRL 8'h00
`define DNM_OFF_CFG 8'h04
`define DNM_OFF_OUT0 8'h08
`define DNM_OFF_OUT1 8'h0c
`define DNM_OFF_OUT2 8'h10
`define DNM_OFF_OUT3 8'h14
`define DNM_OFF_IN0 8'h18
`define DNM_OFF_IN1 8'h1c
`define DNM_OFF_IN2 8'h20
`define DNM_OFF_IN3 8'h24
`define DNM_OFF_ISTAT 8'h28
`define DNM_OFF_IEN 8'h2c
`define DNM_OFF_ICLR 8'h30
// ctrl fields
`define DNM_CTRL_XCHG 0
`define DNM_CTRL_OFLT 1
`define DNM_CTRL_IFLT 2
`define DNM_CTRL_GFLT 3
`define DNM_CTRL_DIAGNOSTIC_FLAG 4
`define DNM_CTRL_RUN 5
`define DNM_CTRL_RST 8'h00
// status byte fields
`define DNM_SB_XCHG 5
// bit rate codes
`define DNM_RATE_125 2'b00
`define DNM_RATE_250 2'b01
`define DNM_RATE_500 2'b10
`define DNM_RATE_BAD 2'b11
// interrupt bits
`define DNM_IRQ_ONLINE 0
`define DNM_IRQ_INPUT 1
`define DNM_IRQ_CFGERR 2
`define DNM_IRQ_W 3
// led blink divider: 0.5 s at 20 MHz
`define DNM_BLINK_MS 500
`define DNM_CLK_KHZ 20000
`define DNM_BLINK_CYC (`DNM_BLINK_MS * `DNM_CLK_KHZ)
`endif

// ===== core/dnm_mapper.v
// fieldbus slave i/o mapper: switches, byte mapping, leds, ahb registers
//
// Operation
// - rate switches: off/off 125k, on/off 250k, off/on 500k
// - six address switches weighted 32..1 give binary address 0..63
// - configure and, unless the rate switches are set to the bad code, go online by itself after power-on or reset
// - virtual output n lands in output byte n/8, bit n%8
// - input byte k bits 0..7 become virtual inputs 8k..8k+7
// - output byte 3 bits 0..4: out fault, in fault, fault, diagnostic_flag, run
// - output byte 3 bit 5 high while cyclic exchange runs
// - 24 virtual i/o by default; entries beyond 24 of a larger NIO are not mapped and read zero
// - drive power, network status and module status indicators
`timescale 1ns/1ns
`include "dnm_consts.vh"
module dnm_mapper #(
  parameter NIO = 24,
  parameter BLINK_CYC = `DNM_BLINK_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // configuration switch pins, no relation to clk_i
  input wire [1:0] bit_rate_switches_i,
  input wire [5:0] addr_switches_i,
  // controller side, on clk_i
  input wire [NIO-1:0] virt_out_i,
  input wire output_fault_flag_i,
  input wire input_fault_flag_i,
  input wire fault_flag_i,
  input wire diagnostic_flag_i,
  input wire run_flag_i,
  // fieldbus side, on clk_i
  input wire [31:0] fb_in_data_i,
  input wire fb_in_valid_i,
  input wire fb_exchange_i,
  // register bus
  input wire hsel_i,
  input wire [7:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // mapped data, captured configuration and indicators
  output reg [NIO-1:0] virt_in_o,
  output reg [31:0] fb_out_data_o,
  output reg [1:0] bit_rate_o,
  output reg [5:0] station_addr_o,
  output reg online_o,
  output wire power_led_o,
  output reg network_status_led_o,
  output reg module_status_led_o,
  output wire irq_o
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // the pin may drop at any time; the flops only lift it on an edge,
  // so no register leaves reset one cycle apart from another
  reg [1:0] rst_sync_r;
  wire rst_n;
  // async assert, sync release
  // every other process resets on rst_n, never on the raw pin
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // switch synchronisers and one-shot capture
  // ----------------------------------------------------------------
  // switches are slow contacts; bounce while one is moved does no harm
  // since the value is read once, long after the flops have settled
  reg [7:0] sw_meta_r;
  reg [7:0] sw_sync_r;
  reg cfg_done_r;
  reg cfg_err_r;
  // two flops before any logic reads the switch pins
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sw_meta_r <= 8'h00;
      sw_sync_r <= 8'h00;
    end else begin
      sw_meta_r <= {bit_rate_switches_i, addr_switches_i};
      sw_sync_r <= sw_meta_r;
    end
  end

  // capture once, a few cycles after release so sync is settled
  // two synchroniser flops plus four settle counts before capture
  // limitation: a switch moved while running is not seen until the
  // next reset, so the node never changes identity on the network
  reg [1:0] settle_r;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      settle_r <= 2'b00;
      cfg_done_r <= 1'b0;
      cfg_err_r <= 1'b0;
      bit_rate_o <= `DNM_RATE_125;
      station_addr_o <= 6'h00;
    end else if (!cfg_done_r) begin
      settle_r <= settle_r + 2'b01;
      if (settle_r == 2'b11) begin
        cfg_done_r <= 1'b1;
        bit_rate_o <= sw_sync_r[7:6];
        station_addr_o <= sw_sync_r[5:0];
        cfg_err_r <= (sw_sync_r[7:6] == `DNM_RATE_BAD);
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_r;
  reg [NIO-1:0] vin_r;
  reg [`DNM_IRQ_W-1:0] istat_r;
  reg [`DNM_IRQ_W-1:0] ien_r;
  reg [7:0] ap_addr_r;
  reg ap_wr_r;
  reg ap_rd_r;
  wire ap_take;
  wire [`DNM_IRQ_W-1:0] ev;
  wire [`DNM_IRQ_W-1:0] clr;
  wire run_en;

  // the slave never stalls, so hready_i alone marks the end of a phase
  // and a held address phase can not be taken twice
  assign ap_take = hsel_i & hready_i & htrans_i[1];
  assign hreadyout_o = 1'b1; // zero wait states
  assign hresp_o = 1'b0; // always okay
  // bad rate means never join the network
  assign run_en = cfg_done_r & ~cfg_err_r;

  // latch address phase
  // only a taken transfer arms the data phase; idle cycles clear it
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ap_addr_r <= 8'h00;
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
    end else if (hready_i) begin
      ap_addr_r <= haddr_i;
      ap_wr_r <= ap_take & hwrite_i;
      ap_rd_r <= ap_take & ~hwrite_i;
    end
  end

  // data phase writes; the bus path is the only writer of ctrl
  // hwdata_i is read one cycle after its address, as the bus expects
  // writes to read-only or unmapped offsets fall through silently
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `DNM_CTRL_RST;
      ien_r <= {`DNM_IRQ_W{1'b0}};
    end else if (ap_wr_r) begin
      if (ap_addr_r == `DNM_OFF_CTRL) begin
        ctrl_r <= hwdata_i[7:0];
      end
      if (ap_addr_r == `DNM_OFF_IEN) begin
        ien_r <= hwdata_i[`DNM_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // cyclic data mapping
  // ----------------------------------------------------------------
  wire xchg;
  wire [7:0] status_byte;
  wire [NIO-1:0] in_bits;
  // exchange needs the link and a node that has already joined; bit 5
  // follows the registered online flag so the inputs and the status bit
  // agree on the cycle in which exchange began
  assign xchg = online_o & fb_exchange_i;
  // bits 7 and 6 of the status byte are spare and stay low
  assign status_byte = {2'b00, xchg, run_flag_i, diagnostic_flag_i,
    fault_flag_i, input_fault_flag_i, output_fault_flag_i};

  // bit n of vector = byte n/8 bit n%8; beyond 24 bits only word 0 used
  // trade-off: extended entries read as zero instead of a second word,
  // which keeps the map of the first three bytes fixed
  genvar g;
  generate
    for (g = 0; g < NIO; g = g + 1) begin : g_in
      if (g < 24) begin : g_map
        assign in_bits[g] = fb_in_data_i[g];
      end else begin : g_ext
        assign in_bits[g] = 1'b0;
      end
    end
  endgenerate

  // inputs only move while exchanging; held otherwise
  // the extra stage keeps virt_in_o a clean flop output even though
  // vin_r is loaded under a gate made from the link strobe
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vin_r <= {NIO{1'b0}};
      virt_in_o <= {NIO{1'b0}};
      fb_out_data_o <= 32'h00000000;
      online_o <= 1'b0;
    end else begin
      online_o <= run_en;
      if (xchg && fb_in_valid_i) begin
        vin_r <= in_bits;
      end
      virt_in_o <= vin_r;
      fb_out_data_o <= {status_byte, virt_out_i[23:0]};
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign ev[`DNM_IRQ_ONLINE] = run_en & ~online_o;
  assign ev[`DNM_IRQ_INPUT] = xchg & fb_in_valid_i;
  assign ev[`DNM_IRQ_CFGERR] = cfg_err_r;
  assign clr = (ap_wr_r && ap_addr_r == `DNM_OFF_ICLR) ?
    hwdata_i[`DNM_IRQ_W-1:0] : {`DNM_IRQ_W{1'b0}};
  // set wins over a clear in the same cycle
  // online event lasts the one cycle before online_o follows run_en
  // bad rate is a level, so its status bit comes back after a clear
  // a clear that meets a new event keeps the event for software
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      istat_r <= {`DNM_IRQ_W{1'b0}};
    end else begin
      istat_r <= (istat_r & ~clr) | ev;
    end
  end
  assign irq_o = |(istat_r & ien_r);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // reads come straight from flops and the xchg gate, so no wait state is needed
  always @* begin
    hrdata_o = 32'h00000000;
    if (ap_rd_r) begin
      case (ap_addr_r)
        `DNM_OFF_CTRL: hrdata_o = {24'h000000, ctrl_r};
        `DNM_OFF_CFG: hrdata_o = {20'h00000, cfg_err_r, cfg_done_r,
          online_o, xchg, bit_rate_o, station_addr_o};
        `DNM_OFF_OUT0: hrdata_o = {24'h000000, fb_out_data_o[7:0]};
        `DNM_OFF_OUT1: hrdata_o = {24'h000000, fb_out_data_o[15:8]};
        `DNM_OFF_OUT2: hrdata_o = {24'h000000, fb_out_data_o[23:16]};
        `DNM_OFF_OUT3: hrdata_o = {24'h000000, fb_out_data_o[31:24]};
        `DNM_OFF_IN0: hrdata_o = {24'h000000, virt_in_o[7:0]};
        `DNM_OFF_IN1: hrdata_o = {24'h000000, virt_in_o[15:8]};
        `DNM_OFF_IN2: hrdata_o = {24'h000000, virt_in_o[23:16]};
        // input byte 3 carries nothing and falls to the default zero
        `DNM_OFF_ISTAT: hrdata_o = {29'h00000000, istat_r};
        `DNM_OFF_IEN: hrdata_o = {29'h00000000, ien_r};
        default: hrdata_o = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  // one half wave lasts BLINK_CYC clocks; the counter runs from reset
  // so both indicators blink in step
  reg [31:0] blink_cnt_r;
  reg blink_r;
  // slow blink for "configured, waiting for master"
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_r <= 32'h00000000;
      blink_r <= 1'b0;
    end else if (blink_cnt_r == BLINK_CYC - 1) begin
      blink_cnt_r <= 32'h00000000;
      blink_r <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h00000001;
    end
  end

  // the power indicator only shows that the core has supply
  assign power_led_o = 1'b1;
  // ns: off unconfigured, blink online idle, solid while exchanging
  // ms: solid good, blink on fault_flag_i, the ctrl fault bit or bad rate setting
  // the controller fault flag and the forced fault bit share the same blink
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      network_status_led_o <= 1'b0;
      module_status_led_o <= 1'b0;
    end else begin
      network_status_led_o <= xchg | (run_en & blink_r);
      if (cfg_err_r || fault_flag_i || ctrl_r[`DNM_CTRL_GFLT]) begin
        module_status_led_o <= blink_r;
      end else begin
        module_status_led_o <= cfg_done_r;
      end
    end
  end
endmodule // dnm_mapper

// ===== testbench/dnm_mapper_asserts.sv
// assertion checker for the fieldbus i/o mapper
`timescale 1ns/1ns
module dnm_mapper_asserts #(
  parameter NIO = 24
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [NIO-1:0] virt_out_i,
  input wire output_fault_flag_i,
  input wire input_fault_flag_i,
  input wire fault_flag_i,
  input wire diagnostic_flag_i,
  input wire run_flag_i,
  input wire [31:0] fb_in_data_i,
  input wire fb_in_valid_i,
  input wire fb_exchange_i,
  input wire [NIO-1:0] virt_in_o,
  input wire [31:0] fb_out_data_o,
  input wire [1:0] bit_rate_o,
  input wire [5:0] station_addr_o,
  input wire online_o,
  input wire power_led_o
);
  reg [3:0] up_r;
  // edges since release; internal reset sync hides the first few
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_r <= 4'h0;
    else if (up_r != 4'hf) up_r <= up_r + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_live; up_r > 4'h3; endsequence
  sequence s_take; fb_in_valid_i && fb_exchange_i && online_o; endsequence
  property p_pwr; power_led_o; endproperty
  a_pwr: assert property (p_pwr) else $error("power led off");
  property p_out;
    s_live |-> fb_out_data_o[23:0] == $past(virt_out_i[23:0]);
  endproperty
  a_out: assert property (p_out) else $error("out bytes wrong");
  property p_sts;
    s_live |-> fb_out_data_o[28:24] == $past({run_flag_i,
      diagnostic_flag_i, fault_flag_i, input_fault_flag_i,
      output_fault_flag_i});
  endproperty
  a_sts: assert property (p_sts) else $error("status bits wrong");
  property p_xchg;
    s_live |-> fb_out_data_o[29] == $past(online_o && fb_exchange_i);
  endproperty
  a_xchg: assert property (p_xchg) else $error("exchange bit");
  property p_in;
    s_take |-> ##2 virt_in_o[23:0] == $past(fb_in_data_i[23:0], 2);
  endproperty
  a_in: assert property (p_in) else $error("input map wrong");
  property p_bad; online_o |-> bit_rate_o != 2'b11; endproperty
  a_bad: assert property (p_bad) else $error("online on bad rate");
  property p_hold;
    online_o |-> $stable(bit_rate_o) && $stable(station_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("config moved");
  property p_cfg;
    up_r == 4'hc && bit_rate_o != 2'b11 |-> online_o;
  endproperty
  a_cfg: assert property (p_cfg) else $error("not online");
endmodule // dnm_mapper_asserts

bind dnm_mapper dnm_mapper_asserts #(.NIO(NIO)) i_dnm_mapper_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .virt_out_i(virt_out_i),
  .output_fault_flag_i(output_fault_flag_i),
  .input_fault_flag_i(input_fault_flag_i), .fault_flag_i(fault_flag_i),
  .diagnostic_flag_i(diagnostic_flag_i), .run_flag_i(run_flag_i),
  .fb_in_data_i(fb_in_data_i), .fb_in_valid_i(fb_in_valid_i),
  .fb_exchange_i(fb_exchange_i), .virt_in_o(virt_in_o),
  .fb_out_data_o(fb_out_data_o), .bit_rate_o(bit_rate_o),
  .station_addr_o(station_addr_o), .online_o(online_o),
  .power_led_o(power_led_o));

// ===== testbench/dnm_master_model.sv
// fieldbus master model driving the input bytes
`timescale 1ns/1ns
module dnm_master_model (
  input wire clk_i,
  output reg [31:0] fb_in_data_o,
  output reg fb_in_valid_o,
  output reg fb_exchange_o
);
  // master owns the input values and the exchange state
  initial begin
    fb_in_data_o = 32'h0;
    fb_in_valid_o = 1'b0;
    fb_exchange_o = 1'b0;
  end
  // one-cycle pulse; data inverted after so stale values never match
  task send(input [31:0] d);
    begin
      fb_in_data_o <= d;
      fb_in_valid_o <= 1'b1;
      @(posedge clk_i);
      fb_in_valid_o <= 1'b0;
      fb_in_data_o <= ~d;
    end
  endtask
  task exch(input e);
    fb_exchange_o <= e;
  endtask
endmodule // dnm_master_model

// ===== testbench/dnm_mapper_bench.sv
// self-checking bench for the fieldbus i/o mapper
`timescale 1ns/1ns
`include "dnm_consts.vh"
module dnm_mapper_bench;
  reg clk, rst_n, hwrite;
  reg hsel;
  reg [2:0] hsize;
  reg [1:0] sw_rate, htrans;
  reg [5:0] sw_addr;
  reg [23:0] vout;
  reg [4:0] flg;
  reg [7:0] haddr;
  reg [31:0] hwdata;
  wire [31:0] hrdata, fbd, fbout;
  wire [23:0] vin;
  wire [1:0] rate;
  wire [5:0] addr;
  wire hrdy, fbv, fbx, online, irq, msled, hresp, pled, nsled;
  integer err_total = 0;
  integer n_checks = 0;
  integer cyc = 0;
  dnm_mapper #(.NIO(24), .BLINK_CYC(4)) i_dnm_mapper (
    .clk_i(clk), .rst_n_i(rst_n), .bit_rate_switches_i(sw_rate),
    .addr_switches_i(sw_addr), .virt_out_i(vout),
    .output_fault_flag_i(flg[0]), .input_fault_flag_i(flg[1]),
    .fault_flag_i(flg[2]), .diagnostic_flag_i(flg[3]), .run_flag_i(flg[4]),
    .fb_in_data_i(fbd), .fb_in_valid_i(fbv), .fb_exchange_i(fbx),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .virt_in_o(vin),
    .fb_out_data_o(fbout), .bit_rate_o(rate), .station_addr_o(addr),
    .online_o(online), .power_led_o(pled), .network_status_led_o(nsled),
    .module_status_led_o(msled),
    .irq_o(irq));
  dnm_master_model i_dnm_master_model (.clk_i(clk), .fb_in_data_o(fbd),
    .fb_in_valid_o(fbv), .fb_exchange_o(fbx));
  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // a hang costs a mismatch; whole run is well under 2000 cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] g, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // single ahb transfer; waits for hready in both phases
  task ahb(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
    begin
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      @(posedge clk);
      while (!hrdy) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk);
      while (!hrdy) @(posedge clk);
      rd = hrdata;
    end
  endtask
  // switches set before release; capture lands on the 6th edge
  task do_reset(input [1:0] r, input [5:0] a);
    begin
      sw_rate <= r;
      sw_addr <= a;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_cfg;
    reg [31:0] rd;
    reg m;
    integer i;
    begin
      i_dnm_master_model.exch(1'b1);
      for (i = 0; i < 4; i = i + 1) begin
        do_reset(i[1:0], 6'h15 * i[5:0]);
        chk("pwr", pled, 1);
        chk("ns", nsled, i != 3);
        m = msled;
        repeat (4) @(posedge clk);
        chk("ms", msled, (i == 3) ? !m : 1);
        chk("rate", rate, {`DNM_RATE_BAD, `DNM_RATE_500, `DNM_RATE_250,
          `DNM_RATE_125} >> (2 * i)  & 8'h3);
        chk("addr", addr, 21 * i);
        chk("online", online, i != 3);
        ahb(1'b0, `DNM_OFF_CFG, 32'h0, rd);
        chk("cfg", {rd[11], rd[9]}, {i == 3, i != 3});
      end
      $display("t_cfg done");
    end
  endtask
  task t_out;
    integer n;
    begin
      for (n = 0; n < 24; n = n + 1) begin
        vout <= 24'h1 << n;
        flg <= n[4:0];
        repeat (2) @(posedge clk);
        chk("out", fbout[23:0], 24'h1 << n);
        chk("status", fbout[28:24], n[4:0]);
      end
      for (n = 0; n < 3; n = n + 1) begin
        i_dnm_master_model.exch(n == 1);
        repeat (2) @(posedge clk);
        chk("xchg", fbout[29], n == 1);
      end
      $display("t_out done");
    end
  endtask
  task t_in;
    begin
      i_dnm_master_model.exch(1'b1);
      @(posedge clk);
      i_dnm_master_model.send(32'h5a3cc3a5);
      repeat (3) @(posedge clk);
      chk("vin", vin, 24'h3cc3a5);
      i_dnm_master_model.exch(1'b0);
      @(posedge clk);
      i_dnm_master_model.send(32'h00ffffff);
      repeat (3) @(posedge clk);
      chk("vin_hold", vin, 24'h3cc3a5);
      $display("t_in done");
    end
  endtask
  // input event raises, masks and clears the interrupt
  task t_irq;
    reg [31:0] rd;
    reg m;
    begin
      flg <= 5'h0;
      ahb(1'b1, `DNM_OFF_ICLR, 32'h7, rd);
      ahb(1'b1, `DNM_OFF_IEN, 32'h2, rd);
      @(posedge clk);
      chk("irq_off", irq, 0);
      i_dnm_master_model.exch(1'b1);
      @(posedge clk);
      i_dnm_master_model.send(32'h1);
      repeat (3) @(posedge clk);
      chk("irq_on", irq, 1);
      ahb(1'b0, `DNM_OFF_ISTAT, 32'h0, rd);
      chk("istat", rd[1], 1);
      ahb(1'b1, `DNM_OFF_IEN, 32'h0, rd);
      @(posedge clk);
      chk("irq_mask", irq, 0);
      ahb(1'b1, `DNM_OFF_ICLR, 32'h2, rd);
      ahb(1'b1, `DNM_OFF_IEN, 32'h2, rd);
      @(posedge clk);
      chk("irq_clr", irq, 0);
      chk("ms_ok", msled, 1);
      ahb(1'b1, `DNM_OFF_CTRL, 32'h8, rd);
      ahb(1'b0, `DNM_OFF_CTRL, 32'h0, rd);
      chk("ctrl", rd, 32'h8);
      m = msled;
      repeat (4) @(posedge clk);
      chk("ms_gflt", msled, !m);
      ahb(1'b1, `DNM_OFF_CTRL, 32'h0, rd);
      ahb(1'b0, 8'h80, 32'h0, rd);
      chk("unmapped", rd, 0);
      chk("hresp", hresp, 0);
      hsel <= 1'b0;
      ahb(1'b1, `DNM_OFF_IEN, 32'h0, rd);
      hsel <= 1'b1;
      ahb(1'b0, `DNM_OFF_IEN, 32'h0, rd);
      chk("ien_sel", rd, 32'h2);
      $display("t_irq done");
    end
  endtask
  task t_sw;
    begin
      sw_rate <= 2'b10;
      sw_addr <= 6'h3f;
      repeat (20) @(posedge clk);
      chk("sw_hold", {rate, addr}, {2'b01, 6'h2a});
      chk("sw_onl", online, 1);
      $display("t_sw done");
    end
  endtask
  initial begin
    rst_n = 1'b0;
    sw_rate = 2'b01;
    sw_addr = 6'h2a;
    vout = 24'h0;
    flg = 5'h0;
    haddr = 8'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    hwdata = 32'h0;
    @(posedge clk);
    do_reset(2'b01, 6'h2a);
    t_out;
    t_in;
    t_irq;
    t_sw;
    t_cfg;
    stop_test;
  end
endmodule // dnm_mapper_bench
